//--- clock_gen_defs.svh
// offsets, field positions, reset values and counts of the clock generator
`ifndef CLOCK_GEN_DEFS_SVH
`define CLOCK_GEN_DEFS_SVH

// ****************************************
// register map, word index of each register and byte address width
// ****************************************
`define ADDR_W          12
`define CLK_SEL_IDX     10'h08f
`define STATUS_IDX      10'h090
`define CLK_SEL_RESET   8'h00

// ****************************************
// field positions of clock_speed_select
// ****************************************
`define CPU_X2_BIT      0
`define PERIPH_LSB      1
`define PERIPH_MSB      7
`define PERIPH_N        7

// ****************************************
// timing counts in oscillator periods
// ****************************************
`define PHASE_LAST      3'h5
`define STD_PERIODS     5'h0c
`define X2_PERIODS      5'h06

// ****************************************
// bus response codes
// ****************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

//--- clock_gen_pkg.sv
// types of the clock generator
package clock_gen_pkg;

  // ****************************************
  // bus channel states
  // ****************************************
  typedef enum logic [0:0] {
    wr_collect,
    wr_respond
  } wr_state_t;

  typedef enum logic [0:0] {
    rd_wait,
    rd_respond
  } rd_state_t;

endpackage : clock_gen_pkg

//--- double_speed_clock_gen.sv
// core and peripheral clock generator with AXI4-Lite register access
//
// Function
// - standard mode divides oscillator by two first
// - machine cycle is 6 or 12 periods
// - reset starts standard unless start-up option
// - cpu bit alone switches the cpu and all peripherals
// - peripheral doubles only with its select cleared
// - double speed bypasses the divider
// - speed change applied on divided rising edge
// - start-up option resets into double speed
// - doubled peripherals see halved time reference
// - cpu bit clear keeps everything at 12
// - cleared select gives 6, set gives 12
`include "clock_gen_defs.svh"

module double_speed_clock_gen (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 boot_double_speed_opt,
  input  wire logic [`ADDR_W-1:0]   awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [`ADDR_W-1:0]   araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic                      cpu_clk_en,
  output logic                      cpu_cycle,
  output logic [`PERIPH_N-1:0]      periph_clk_en,
  output logic [`PERIPH_N-1:0]      periph_cycle,
  output logic                      cpu_double_active
);

  // ****************************************
  // divider and applied speed
  // ****************************************
  logic                 div_q;
  logic                 div_d;
  logic                 div_rise;
  logic                 cpu_fast_q;
  logic                 cpu_fast_d;
  logic [`PERIPH_N-1:0] periph_fast_q;
  logic [`PERIPH_N-1:0] periph_fast_d;
  logic [7:0]           sel_q;
  logic [7:0]           sel_d;

  localparam logic [7:0] SEL_RESET = `CLK_SEL_RESET;

  always_comb begin
    div_d         = ~div_q;
    div_rise      = ~div_q;
    cpu_fast_d    = cpu_fast_q;
    periph_fast_d = periph_fast_q;
    if (div_rise) begin
      cpu_fast_d    = sel_q[`CPU_X2_BIT];
      periph_fast_d = {`PERIPH_N{sel_q[`CPU_X2_BIT]}}
                      & ~sel_q[`PERIPH_MSB:`PERIPH_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q         <= 1'b0;
      cpu_fast_q    <= boot_double_speed_opt;
      periph_fast_q <= {`PERIPH_N{boot_double_speed_opt}};
    end else if (ce) begin
      div_q         <= div_d;
      cpu_fast_q    <= cpu_fast_d;
      periph_fast_q <= periph_fast_d;
    end
  end

  // ****************************************
  // enable generators, core first
  // ****************************************
  logic [`PERIPH_N:0] fast_vec;
  logic [`PERIPH_N:0] clk_en_vec;
  logic [`PERIPH_N:0] cycle_vec;

  assign fast_vec = {periph_fast_q, cpu_fast_q};

  generate
    for (genvar i = 0; i <= `PERIPH_N; i++) begin : g_gen
      periph_clk_gen u_gen (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .div_rise (div_rise),
        .fast     (fast_vec[i]),
        .clk_en_q (clk_en_vec[i]),
        .cycle_q  (cycle_vec[i])
      );
    end
  endgenerate

  assign cpu_clk_en        = clk_en_vec[0];
  assign cpu_cycle         = cycle_vec[0];
  assign periph_clk_en     = clk_en_vec[`PERIPH_N:1];
  assign periph_cycle      = cycle_vec[`PERIPH_N:1];
  assign cpu_double_active = cpu_fast_q;

  // ****************************************
  // write channels
  // ****************************************
  clock_gen_pkg::wr_state_t wr_state_q;
  clock_gen_pkg::wr_state_t wr_state_d;
  logic                     aw_got_q;
  logic                     aw_got_d;
  logic                     w_got_q;
  logic                     w_got_d;
  logic [`ADDR_W-1:0]       awaddr_q;
  logic [`ADDR_W-1:0]       awaddr_d;
  logic [7:0]               wbyte_q;
  logic [7:0]               wbyte_d;
  logic                     wlane_q;
  logic                     wlane_d;
  logic                     awready_d;
  logic                     wready_d;
  logic                     bvalid_d;
  logic [1:0]               bresp_d;

  always_comb begin
    wr_state_d = wr_state_q;
    aw_got_d   = aw_got_q;
    w_got_d    = w_got_q;
    awaddr_d   = awaddr_q;
    wbyte_d    = wbyte_q;
    wlane_d    = wlane_q;
    awready_d  = awready;
    wready_d   = wready;
    bvalid_d   = bvalid;
    bresp_d    = bresp;
    sel_d      = sel_q;
    case (wr_state_q)
      clock_gen_pkg::wr_collect: begin
        if (awvalid && awready) begin
          aw_got_d = 1'b1;
          awaddr_d = awaddr;
        end
        if (wvalid && wready) begin
          w_got_d = 1'b1;
          wbyte_d = wdata[7:0];
          wlane_d = wstrb[0];
        end
        awready_d = ~aw_got_d;
        wready_d  = ~w_got_d;
        if (aw_got_d && w_got_d) begin
          if (awaddr_d[`ADDR_W-1:2] == `CLK_SEL_IDX) begin
            if (wlane_d) begin
              sel_d = wbyte_d;
            end
            bresp_d = `RESP_OKAY;
          end else if (awaddr_d[`ADDR_W-1:2] == `STATUS_IDX) begin
            bresp_d = `RESP_OKAY;
          end else begin
            bresp_d = `RESP_SLVERR;
          end
          bvalid_d   = 1'b1;
          aw_got_d   = 1'b0;
          w_got_d    = 1'b0;
          awready_d  = 1'b0;
          wready_d   = 1'b0;
          wr_state_d = clock_gen_pkg::wr_respond;
        end
      end
      clock_gen_pkg::wr_respond: begin
        if (bready) begin
          bvalid_d   = 1'b0;
          awready_d  = 1'b1;
          wready_d   = 1'b1;
          wr_state_d = clock_gen_pkg::wr_collect;
        end
      end
      default: begin
        wr_state_d = clock_gen_pkg::wr_collect;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= clock_gen_pkg::wr_collect;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      awaddr_q   <= '0;
      wbyte_q    <= 8'h00;
      wlane_q    <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      sel_q      <= {SEL_RESET[7:1], boot_double_speed_opt};
    end else if (ce) begin
      wr_state_q <= wr_state_d;
      aw_got_q   <= aw_got_d;
      w_got_q    <= w_got_d;
      awaddr_q   <= awaddr_d;
      wbyte_q    <= wbyte_d;
      wlane_q    <= wlane_d;
      awready    <= awready_d;
      wready     <= wready_d;
      bvalid     <= bvalid_d;
      bresp      <= bresp_d;
      sel_q      <= sel_d;
    end
  end

  // ****************************************
  // read channels
  // ****************************************
  clock_gen_pkg::rd_state_t rd_state_q;
  clock_gen_pkg::rd_state_t rd_state_d;
  logic                     arready_d;
  logic                     rvalid_d;
  logic [31:0]              rdata_d;
  logic [1:0]               rresp_d;

  always_comb begin
    rd_state_d = rd_state_q;
    arready_d  = arready;
    rvalid_d   = rvalid;
    rdata_d    = rdata;
    rresp_d    = rresp;
    case (rd_state_q)
      clock_gen_pkg::rd_wait: begin
        arready_d = 1'b1;
        if (arvalid && arready) begin
          if (araddr[`ADDR_W-1:2] == `CLK_SEL_IDX) begin
            rdata_d = {24'h000000, sel_q};
            rresp_d = `RESP_OKAY;
          end else if (araddr[`ADDR_W-1:2] == `STATUS_IDX) begin
            rdata_d = {24'h000000, periph_fast_q, cpu_fast_q};
            rresp_d = `RESP_OKAY;
          end else begin
            rdata_d = 32'h00000000;
            rresp_d = `RESP_SLVERR;
          end
          rvalid_d   = 1'b1;
          arready_d  = 1'b0;
          rd_state_d = clock_gen_pkg::rd_respond;
        end
      end
      clock_gen_pkg::rd_respond: begin
        if (rready) begin
          rvalid_d   = 1'b0;
          arready_d  = 1'b1;
          rd_state_d = clock_gen_pkg::rd_wait;
        end
      end
      default: begin
        rd_state_d = clock_gen_pkg::rd_wait;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= clock_gen_pkg::rd_wait;
      arready    <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= 32'h00000000;
      rresp      <= `RESP_OKAY;
    end else if (ce) begin
      rd_state_q <= rd_state_d;
      arready    <= arready_d;
      rvalid     <= rvalid_d;
      rdata      <= rdata_d;
      rresp      <= rresp_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence div_edge_s;
    ce && div_rise;
  endsequence

  sequence settle_s;
    ##1 (periph_fast_q == $past(~sel_q[`PERIPH_MSB:`PERIPH_LSB]
                                & {`PERIPH_N{sel_q[`CPU_X2_BIT]}}));
  endsequence

  div_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> div_q != $past(div_q))
    else $error("divider did not toggle");

  reset_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (cpu_fast_q == $past(boot_double_speed_opt))
                       && (sel_q[`CPU_X2_BIT] == $past(boot_double_speed_opt)))
    else $error("reset speed does not follow the start-up option");

  mode_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(ce && div_rise) |=> $stable(cpu_fast_q) && $stable(periph_fast_q))
    else $error("speed changed off the divided edge");

  cpu_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
    div_edge_s |=> cpu_fast_q == $past(sel_q[`CPU_X2_BIT]))
    else $error("cpu speed not applied at the divided edge");

  periph_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    div_edge_s |-> settle_s)
    else $error("peripheral speed does not follow its select");

  std_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cpu_fast_q |-> periph_fast_q == '0)
    else $error("peripheral fast while cpu in standard mode");

  cpu_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && cpu_fast_q) ##1 ce |-> cpu_clk_en)
    else $error("cpu not clocked every period in double speed");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule : double_speed_clock_gen

//--- double_speed_clock_gen_tb.sv
// self-checking bench of the double speed clock generator
`include "clock_gen_defs.svh"

module double_speed_clock_gen_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****
  // signals
  // ****
  localparam logic [11:0] CTRL_A = {`CLK_SEL_IDX, 2'h0};
  localparam logic [11:0] STAT_A = {`STATUS_IDX, 2'h0};
  localparam logic [11:0] BAD_A  = 12'h100;

  logic                aclk;
  logic                aresetn;
  logic                ce;
  logic                boot_double_speed_opt;
  logic [`ADDR_W-1:0]  awaddr;
  logic [`ADDR_W-1:0]  araddr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp;
  logic [1:0]          rresp;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  logic                cpu_clk_en, cpu_cycle, cpu_double_active;
  logic [`PERIPH_N-1:0] periph_clk_en;
  logic [`PERIPH_N-1:0] periph_cycle;
  logic [15:0]         pulses;
  int                  miscompares;
  int                  checks;
  int                  cycles;

  assign pulses = {periph_clk_en, cpu_clk_en, cpu_cycle, periph_cycle};

  osc_model u_osc (.aclk(aclk));

  double_speed_clock_gen u_dut (
    .aclk, .aresetn, .ce, .boot_double_speed_opt,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .cpu_clk_en, .cpu_cycle,
    .periph_clk_en, .periph_cycle, .cpu_double_active
  );

  // ****
  // tasks
  // ****
  task stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
          input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'h0;
    wd = 1'h0;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'h1) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (!wd && wready === 1'h1) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    @(posedge aclk);
    bready <= 1'h1;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready  <= 1'h1;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, {24'h000000, exp});
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // skips one interval after a switch, then counts the next one
  task period(input int b, input int exp);
    int n;
    n = 0;
    do @(posedge aclk); while (pulses[b] !== 1'h1);
    do @(posedge aclk); while (pulses[b] !== 1'h1);
    do begin
      @(posedge aclk);
      n++;
    end while (pulses[b] !== 1'h1);
    chk(n, exp);
  endtask : period

  task all_periods(input logic [7:0] v);
    period(8, v[0] ? 1 : 2);
    period(7, v[0] ? 6 : 12);
    for (int b = 0; b < 7; b++) begin
      period(b, (v[0] && !v[b+1]) ? 6 : 12);
      period(b + 9, (v[0] && !v[b+1]) ? 1 : 2);
    end
  endtask : all_periods

  task mode(input logic [7:0] v, input logic [7:0] st);
    int n;
    n = 0;
    wr(CTRL_A, v, 4'h1, `RESP_OKAY);
    do begin
      @(posedge aclk);
      n++;
    end while (cpu_double_active !== v[0] && n < 8);
    chk({31'h0, cpu_double_active}, {31'h0, v[0]});
    rd(STAT_A, st, `RESP_OKAY);
    all_periods(v);
  endtask : mode

  task do_reset(input logic opt);
    aresetn <= 1'h0;
    boot_double_speed_opt <= opt;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  // ****
  // timeout and main sequence
  // ****
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test;
    end
  end

  initial begin
    {aresetn, boot_double_speed_opt, awvalid, wvalid, bready} = 5'h00;
    {arvalid, rready, awaddr, araddr, wdata, wstrb} = 62'h0;
    ce = 1'h1;
    cycles = 0;
    miscompares = 0;
    checks = 0;
    do_reset(1'h0);
    rd(CTRL_A, `CLK_SEL_RESET, `RESP_OKAY);
    rd(STAT_A, 8'h00, `RESP_OKAY);
    all_periods(8'h00);
    mode(8'hfe, 8'h00);
    mode(8'hff, 8'h01);
    mode(8'h55, 8'hab);
    mode(8'h01, 8'hff);
    wr(CTRL_A, 8'h00, 4'h0, `RESP_OKAY);
    rd(CTRL_A, 8'h01, `RESP_OKAY);
    wr(BAD_A, 8'h12, 4'h1, `RESP_SLVERR);
    rd(BAD_A, 8'h00, `RESP_SLVERR);
    wr(STAT_A, 8'h00, 4'h1, `RESP_OKAY);
    rd(STAT_A, 8'hff, `RESP_OKAY);
    mode(8'h00, 8'h00);
    do_reset(1'h1);
    rd(CTRL_A, 8'h01, `RESP_OKAY);
    rd(STAT_A, 8'hff, `RESP_OKAY);
    all_periods(8'h01);
    stop_test;
  end
endmodule : double_speed_clock_gen_tb

//--- osc_model.sv
// oscillator source feeding the block clock input
module osc_model (
  output logic aclk
);
  timeunit 1ns;
  timeprecision 100ps;

  initial aclk = 1'h0;
  always #2 aclk = ~aclk;
endmodule : osc_model

//--- periph_clk_gen.sv
// one clock enable and cycle pulse generator for the core or a peripheral
`include "clock_gen_defs.svh"

module periph_clk_gen (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic div_rise,
  input  wire logic fast,
  output logic      clk_en_q,
  output logic      cycle_q
);

  // ****************************************
  // phase generator
  // ****************************************
  logic [2:0] phase_q;
  logic [2:0] phase_d;
  logic       clk_en_d;
  logic       cycle_d;
  logic       tick;

  always_comb begin
    tick     = fast | div_rise;
    phase_d  = phase_q;
    clk_en_d = 1'b0;
    cycle_d  = 1'b0;
    if (tick) begin
      clk_en_d = 1'b1;
      if (phase_q == `PHASE_LAST) begin
        phase_d = 3'h0;
        cycle_d = 1'b1;
      end else begin
        phase_d = phase_q + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q  <= 3'h0;
      clk_en_q <= 1'b0;
      cycle_q  <= 1'b0;
    end else if (ce) begin
      phase_q  <= phase_d;
      clk_en_q <= clk_en_d;
      cycle_q  <= cycle_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [4:0] gap_q;
  logic       mixed_q;
  logic       seen_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q   <= 5'h00;
      mixed_q <= 1'b1;
      seen_q  <= 1'b0;
    end else if (ce) begin
      if (cycle_q) begin
        gap_q   <= 5'h01;
        mixed_q <= 1'b0;
        seen_q  <= fast;
      end else begin
        gap_q   <= gap_q + 5'h01;
        mixed_q <= mixed_q | (fast != seen_q);
      end
    end
  end

  cycle_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && cycle_q && !mixed_q) |-> gap_q == (seen_q ? `X2_PERIODS : `STD_PERIODS))
    else $error("cycle length does not match the applied speed");

  fast_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && fast) |=> clk_en_q)
    else $error("double speed missed an oscillator period");

  std_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !fast && !div_rise) |=> !clk_en_q)
    else $error("standard speed ticked off the divided edge");

endmodule : periph_clk_gen
